/* File: vcr_control_regs.sv */
// Control register bank of the video codec: configuration, gain word and clamp timers.
// Assumes a serial bus controller outside that handles the subaddress and auto-increment,
// issuing one-cycle write or read strobes on clk; sync_in arrives asynchronously.
//
// What this block does
// (R01) Four-bit converter power-down field, zero enables converter.
// (R02) Dual-edge bit selects both-edge input capture.
// (R03) Dual-clock bit allows two input clocks.
// (R04) 4:2:2 works only with both clocking bits clear.
// (R05) Invert bit inverts converter input data.
// (R06) Four-bit field selects analog input configuration.
// (R07) Sample-and-hold power-down bits, zero enables.
// (R08) Auxiliary converter power-down bit, zero enables.
// (R09) Clamp-current bit halves all clamp currents.
// (R10) Input-mode bit selects differential analog inputs.
// (R11) Sample-and-hold gain bit: one or two.
// (R12) Voltage-clamp bit enables voltage clamps.
// (R13) Output-disable bit tri-states digital outputs.
// (R14) Sync polarity bit defines active sync level.
// (R15) Gain word: eight low, four high bits.
// (R16) Gain sync gate waits for next sync.
// (R17) Seven-bit black level, value over sixteen.
// (R18) Fine and coarse clamp on-time fields.
// (R19) Clamp sync gate waits for next sync.
// (R20) Fine clamp direction and trigger bits.
// (R21) Coarse clamp direction and trigger bits.
// (R22) Host writes zero to reserved bits.
// (R23) Clamp triggers fire on zero-to-one only.
// (R24) Ungated clamps start now, gated on sync.
// (R25) All bank registers read and write.
// (R26) On-time counts clock cycles, then clamp ends.

module vcr_control_regs
(
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    input  wire vcr_pkg::vcr_reg_request_type request,
    output logic                        request_ack,
    output vcr_pkg::vcr_byte_type       read_data,
    input  wire logic                   sync_in,
    output vcr_pkg::vcr_config_type     config_out,
    output vcr_pkg::vcr_clamp_type      clamp_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // Decoding shared by the ack and the register access

    function automatic logic vcr_addr_valid(input logic [7:0] addr);
        vcr_addr_valid = (addr >= `VCR_ADDR_FIRST) && (addr <= `VCR_ADDR_LAST);
    endfunction

    function automatic logic [`VCR_IDX_WIDTH-1:0] vcr_addr_index(input logic [7:0] addr);
        logic [7:0] offset;
        offset = addr - `VCR_ADDR_FIRST;
        vcr_addr_index = offset[`VCR_IDX_WIDTH-1:0];
    endfunction

    vcr_pkg::vcr_state_type state;
    vcr_pkg::vcr_state_type next_state;

    logic                              sync_active;
    logic                              sync_edge;
    logic [`VCR_CLAMP_COUNT-1:0]       trigger;
    logic [`VCR_CLAMP_COUNT-1:0]       direction;
    logic [`VCR_CLAMP_COUNT-1:0][2:0]  on_time;
    logic                              clamp_gate;
    logic                              gain_write;
    logic                              start;
    logic                              rise;

    // Unmapped subaddresses are not acknowledged; the controller then drops the transfer
    assign request_ack = vcr_addr_valid(request.subaddress);
    assign read_data   = state.read_data;

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        next_state = state;
        start      = 1'b0;
        rise       = 1'b0;

        // Plain two-stage synchroniser on the sync pin
        next_state.sync_meta   = sync_in;
        next_state.sync_stable = state.sync_meta;
        next_state.sync_prev   = sync_active;

        // (R25) host register access
        if (request.write && request_ack)
        begin
            next_state.regs[vcr_addr_index(request.subaddress)] = request.write_data;
        end
        if (request.read && request_ack)
        begin
            next_state.read_data = state.regs[vcr_addr_index(request.subaddress)];
        end

        // (R16) gain waits for sync when gated
        if (gain_write)
        begin
            next_state.gain_on      = ~next_state.regs[`VCR_IDX_GAIN_HIGH][`VCR_BIT_GAIN_SYNC_GATE];
            next_state.gain_pending = next_state.regs[`VCR_IDX_GAIN_HIGH][`VCR_BIT_GAIN_SYNC_GATE];
        end
        else if (state.gain_pending && sync_edge)
        begin
            next_state.gain_on      = 1'b1;
            next_state.gain_pending = 1'b0;
        end

        for (int i = 0; i < `VCR_CLAMP_COUNT; i++)
        begin
            // (R23) fire on rising trigger only
            rise = trigger[i] & ~state.trigger_prev[i];
            next_state.trigger_prev[i] = trigger[i];

            // (R26) count down cycles
            if (state.count[i] != `VCR_COUNT_ZERO)
            begin
                next_state.count[i] = 3'(state.count[i] - `VCR_COUNT_STEP);
            end

            // (R24) immediate or sync-timed start
            start = (rise & ~clamp_gate) | (state.pending[i] & sync_edge);
            // (R19) hold until next sync
            if (rise && clamp_gate)
            begin
                next_state.pending[i] = 1'b1;
            end
            // (R18) load programmed on-time
            if (start)
            begin
                next_state.count[i]   = on_time[i];
                next_state.pending[i] = 1'b0;
            end
            next_state.clamp_on[i] = (next_state.count[i] != `VCR_COUNT_ZERO);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sync qualification and clamp field views

    always_comb
    begin
        // (R14) normalise sync to active-high
        sync_active = state.regs[`VCR_IDX_FRONT_MODE][`VCR_BIT_SYNC_POLARITY]
                      ? state.sync_stable : ~state.sync_stable;
        sync_edge   = sync_active & ~state.sync_prev;
        clamp_gate  = state.regs[`VCR_IDX_CLAMP_TIMING][`VCR_BIT_CLAMP_SYNC_GATE];
        gain_write  = request.write && request_ack
                      && ((request.subaddress == `VCR_ADDR_GAIN_LOW)
                          || (request.subaddress == `VCR_ADDR_GAIN_HIGH));
        for (int i = 0; i < `VCR_CLAMPS_PER_GROUP; i++)
        begin
            // (R20) fine clamp bit pairs
            direction[i] = state.regs[`VCR_IDX_FINE_CLAMP][2*i];
            trigger[i]   = state.regs[`VCR_IDX_FINE_CLAMP][2*i+1];
            on_time[i]   = state.regs[`VCR_IDX_CLAMP_TIMING][`VCR_FINE_TIME_MSB:`VCR_FINE_TIME_LSB];
            // (R21) coarse clamp bit pairs
            direction[i+`VCR_CLAMPS_PER_GROUP] = state.regs[`VCR_IDX_COARSE_CLAMP][2*i];
            trigger[i+`VCR_CLAMPS_PER_GROUP]   = state.regs[`VCR_IDX_COARSE_CLAMP][2*i+1];
            on_time[i+`VCR_CLAMPS_PER_GROUP]   =
                state.regs[`VCR_IDX_CLAMP_TIMING][`VCR_COARSE_TIME_MSB:`VCR_COARSE_TIME_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration outputs from stored bits; 4:2:2 active is also gated by both clock modes

    always_comb
    begin
        // (R01) converter power-down
        config_out.converter_power_down =
            state.regs[`VCR_IDX_OUTPUT_CONFIG][`VCR_CONV_PD_MSB:`VCR_CONV_PD_LSB];
        // (R02) dual-edge capture
        config_out.dual_edge_select  = state.regs[`VCR_IDX_OUTPUT_CONFIG][`VCR_BIT_DUAL_EDGE];
        // (R03) dual-clock capture
        config_out.dual_clock_select = state.regs[`VCR_IDX_OUTPUT_CONFIG][`VCR_BIT_DUAL_CLOCK];
        config_out.subsampled_chroma_select = state.regs[`VCR_IDX_OUTPUT_CONFIG][`VCR_BIT_CHROMA_422];
        // (R04) 4:2:2 blocked by either clock mode
        config_out.chroma_422_active = state.regs[`VCR_IDX_OUTPUT_CONFIG][`VCR_BIT_CHROMA_422]
                                       & ~state.regs[`VCR_IDX_OUTPUT_CONFIG][`VCR_BIT_DUAL_EDGE]
                                       & ~state.regs[`VCR_IDX_OUTPUT_CONFIG][`VCR_BIT_DUAL_CLOCK];
        // (R05) input inversion
        config_out.converter_input_invert = state.regs[`VCR_IDX_OUTPUT_CONFIG][`VCR_BIT_INPUT_INVERT];
        // (R06) analog input configuration
        config_out.input_config   = state.regs[`VCR_IDX_INPUT_CONFIG][`VCR_INCFG_MSB:`VCR_INCFG_LSB];
        // (R07) sample-and-hold power-down
        config_out.sha_power_down = state.regs[`VCR_IDX_INPUT_CONFIG][`VCR_SHA_PD_MSB:`VCR_SHA_PD_LSB];
        // (R08) auxiliary converter power-down
        config_out.aux_power_down = state.regs[`VCR_IDX_INPUT_CONFIG][`VCR_BIT_AUX_PD];
        // (R09) half clamp current
        config_out.clamp_current_half     = state.regs[`VCR_IDX_FRONT_MODE][`VCR_BIT_CLAMP_HALF];
        // (R10) differential inputs
        config_out.differential_inputs    = state.regs[`VCR_IDX_FRONT_MODE][`VCR_BIT_DIFFERENTIAL];
        // (R11) gain of two
        config_out.sha_gain_two           = state.regs[`VCR_IDX_FRONT_MODE][`VCR_BIT_SHA_GAIN];
        // (R12) voltage clamps
        config_out.voltage_clamp_enable   = state.regs[`VCR_IDX_FRONT_MODE][`VCR_BIT_VOLTAGE_CLAMP];
        // (R13) digital output tri-state
        config_out.digital_output_disable = state.regs[`VCR_IDX_FRONT_MODE][`VCR_BIT_OUTPUT_DISABLE];
        config_out.sync_polarity_select   = state.regs[`VCR_IDX_FRONT_MODE][`VCR_BIT_SYNC_POLARITY];
        // (R15) assemble twelve-bit gain word
        config_out.gain_multiplier = {state.regs[`VCR_IDX_GAIN_HIGH][`VCR_GAIN_HIGH_MSB:`VCR_GAIN_HIGH_LSB],
                                      state.regs[`VCR_IDX_GAIN_LOW]};
        config_out.gain_active     = state.gain_on;
        // (R17) black level over sixteen
        config_out.black_level = state.regs[`VCR_IDX_BLACK_LEVEL][`VCR_BLACK_MSB:`VCR_BLACK_LSB];

        // Direction only matters while the clamp runs, so it is masked when idle
        clamp_out.fine_on   = state.clamp_on[`VCR_CLAMPS_PER_GROUP-1:0];
        clamp_out.fine_up   = state.clamp_on[`VCR_CLAMPS_PER_GROUP-1:0]
                              & direction[`VCR_CLAMPS_PER_GROUP-1:0];
        clamp_out.coarse_on = state.clamp_on[`VCR_CLAMP_COUNT-1:`VCR_CLAMPS_PER_GROUP];
        clamp_out.coarse_up = state.clamp_on[`VCR_CLAMP_COUNT-1:`VCR_CLAMPS_PER_GROUP]
                              & direction[`VCR_CLAMP_COUNT-1:`VCR_CLAMPS_PER_GROUP];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state              <= '0;
            for (int i = 0; i < `VCR_REG_DEPTH; i++)
            begin
                state.regs[i]  <= `VCR_RESET_VALUE;
            end
            // Sync idles high under the reset polarity, so no false edge
            state.sync_meta    <= 1'b1;
            state.sync_stable  <= 1'b1;
            // Gain runs ungated out of reset
            state.gain_on      <= 1'b1;
        end
        else
        begin
            state <= next_state;
        end
    end

endmodule

/* File: vcr_defs.svh */
// Constants of the codec control register bank: subaddresses, bit fields, reset values.
// Assumes inclusion by bare name from the package, ahead of the bank itself.
`ifndef VCR_DEFS_SVH
`define VCR_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// Subaddresses held by this bank
`define VCR_ADDR_OUTPUT_CONFIG   8'h01
`define VCR_ADDR_INPUT_CONFIG    8'h02
`define VCR_ADDR_FRONT_MODE      8'h03
`define VCR_ADDR_GAIN_LOW        8'h04
`define VCR_ADDR_GAIN_HIGH       8'h05
`define VCR_ADDR_BLACK_LEVEL     8'h06
`define VCR_ADDR_CLAMP_TIMING    8'h07
`define VCR_ADDR_FINE_CLAMP      8'h08
`define VCR_ADDR_COARSE_CLAMP    8'h09
`define VCR_ADDR_FIRST           8'h01
`define VCR_ADDR_LAST            8'h09

// Storage index is the subaddress less the first one
`define VCR_IDX_OUTPUT_CONFIG    0
`define VCR_IDX_INPUT_CONFIG     1
`define VCR_IDX_FRONT_MODE       2
`define VCR_IDX_GAIN_LOW         3
`define VCR_IDX_GAIN_HIGH        4
`define VCR_IDX_BLACK_LEVEL      5
`define VCR_IDX_CLAMP_TIMING     6
`define VCR_IDX_FINE_CLAMP       7
`define VCR_IDX_COARSE_CLAMP     8
`define VCR_REG_DEPTH            9
`define VCR_IDX_WIDTH            4

////////////////////////////////////////////////////////////////////////////////
// Converter output configuration fields
`define VCR_CONV_PD_LSB          0
`define VCR_CONV_PD_MSB          3
`define VCR_BIT_DUAL_EDGE        4
`define VCR_BIT_DUAL_CLOCK       5
`define VCR_BIT_CHROMA_422       6
`define VCR_BIT_INPUT_INVERT     7

// Analog input configuration fields
`define VCR_INCFG_LSB            0
`define VCR_INCFG_MSB            3
`define VCR_SHA_PD_LSB           4
`define VCR_SHA_PD_MSB           6
`define VCR_BIT_AUX_PD           7

// Analog front mode fields
`define VCR_BIT_CLAMP_HALF       0
`define VCR_BIT_DIFFERENTIAL     1
`define VCR_BIT_SHA_GAIN         2
`define VCR_BIT_VOLTAGE_CLAMP    3
`define VCR_BIT_OUTPUT_DISABLE   4
`define VCR_BIT_SYNC_POLARITY    5

// Gain multiplier and gating
`define VCR_GAIN_HIGH_LSB        0
`define VCR_GAIN_HIGH_MSB        3
`define VCR_BIT_GAIN_SYNC_GATE   4

// Black level and clamp timing
`define VCR_BLACK_LSB            0
`define VCR_BLACK_MSB            6
`define VCR_FINE_TIME_LSB        0
`define VCR_FINE_TIME_MSB        2
`define VCR_COARSE_TIME_LSB      3
`define VCR_COARSE_TIME_MSB      5
`define VCR_BIT_CLAMP_SYNC_GATE  6

// Per-clamp pairs: direction at 2i, trigger at 2i+1
`define VCR_CLAMPS_PER_GROUP     3
`define VCR_CLAMP_COUNT          6

// Reset value and clamp count constants
`define VCR_RESET_VALUE          8'h00
`define VCR_COUNT_ZERO           3'h0
`define VCR_COUNT_STEP           3'h1

`endif

/* File: vcr_pkg.sv */
// Types shared by the codec control register bank and its surroundings.
// Assumes vcr_defs.svh is on the include path.
`include "vcr_defs.svh"

package vcr_pkg;

    typedef logic [7:0] vcr_byte_type;

    // Register port from the serial bus controller
    typedef struct packed {
        logic         write;
        logic         read;
        logic [7:0]   subaddress;
        vcr_byte_type write_data;
    } vcr_reg_request_type;

    // Static configuration driven to the analog and converter sections
    typedef struct packed {
        logic [3:0]  converter_power_down;
        logic        dual_edge_select;
        logic        dual_clock_select;
        logic        subsampled_chroma_select;
        logic        chroma_422_active;
        logic        converter_input_invert;
        logic [3:0]  input_config;
        logic [2:0]  sha_power_down;
        logic        aux_power_down;
        logic        clamp_current_half;
        logic        differential_inputs;
        logic        sha_gain_two;
        logic        voltage_clamp_enable;
        logic        digital_output_disable;
        logic        sync_polarity_select;
        logic [11:0] gain_multiplier;
        logic        gain_active;
        logic [6:0]  black_level;
    } vcr_config_type;

    // Live clamp drive
    typedef struct packed {
        logic [2:0] fine_on;
        logic [2:0] fine_up;
        logic [2:0] coarse_on;
        logic [2:0] coarse_up;
    } vcr_clamp_type;

    // Whole state of the bank
    typedef struct packed {
        vcr_byte_type [`VCR_REG_DEPTH-1:0]   regs;
        vcr_byte_type                        read_data;
        logic                                sync_meta;
        logic                                sync_stable;
        logic                                sync_prev;
        logic                                gain_on;
        logic                                gain_pending;
        logic [`VCR_CLAMP_COUNT-1:0]         trigger_prev;
        logic [`VCR_CLAMP_COUNT-1:0]         pending;
        logic [`VCR_CLAMP_COUNT-1:0]         clamp_on;
        logic [`VCR_CLAMP_COUNT-1:0][2:0]    count;
    } vcr_state_type;

endpackage

/* File: vcr_control_regs_assertions.sv */
// Port-level checks of the codec control register bank.
// Assumes one clock domain and a bind from the bench top file.
module vcr_control_regs_assertions
(
    input wire logic                         clk,
    input wire logic                         reset_n,
    input wire vcr_pkg::vcr_reg_request_type request,
    input wire logic                         request_ack,
    input wire vcr_pkg::vcr_byte_type        read_data,
    input wire logic                         sync_in,
    input wire vcr_pkg::vcr_config_type      config_out,
    input wire vcr_pkg::vcr_clamp_type       clamp_out
);
    logic       wr_ok;
    logic [7:0] sub;
    logic [5:0] mode;
    logic [7:0] timing;
    logic [7:0] fine;
    logic [3:0] run;
    assign wr_ok = request.write && request_ack;
    assign sub = request.subaddress;
    assign mode = {config_out.sync_polarity_select, config_out.digital_output_disable,
                   config_out.voltage_clamp_enable, config_out.sha_gain_two,
                   config_out.differential_inputs, config_out.clamp_current_half};
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////////////
    // Shadows from accepted writes; run length of fine clamp 0
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            timing <= 8'h00;
            fine <= 8'h00;
            run <= 4'h0;
        end
        else
        begin
            if (wr_ok && sub == 8'h07)
                timing <= request.write_data;
            if (wr_ok && sub == 8'h08)
                fine <= request.write_data;
            run <= clamp_out.fine_on[0] ? run + 4'h1 : 4'h0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_ack_decode: assert property (request_ack == (sub >= 8'h01 && sub <= 8'h09))
        else $error("ack does not follow subaddress");
    a_power_write: assert property (wr_ok && sub == 8'h01 |=>
        config_out.converter_power_down == $past(request.write_data[3:0]))
        else $error("converter power bits wrong");
    a_chroma_gate: assert property (config_out.chroma_422_active ==
        (config_out.subsampled_chroma_select && !config_out.dual_edge_select
         && !config_out.dual_clock_select))
        else $error("4:2:2 gating wrong");
    a_gain_low: assert property (wr_ok && sub == 8'h04 |=>
        config_out.gain_multiplier[7:0] == $past(request.write_data))
        else $error("gain low byte wrong");
    a_gain_gate: assert property (wr_ok && sub == 8'h05 && request.write_data[4] |=>
        !config_out.gain_active)
        else $error("gain not gated");
    a_mode_read: assert property (request.read && request_ack && !request.write
        && sub == 8'h03 |=> read_data[5:0] == $past(mode))
        else $error("mode read back wrong");
    a_mode_hold: assert property (!(wr_ok && sub == 8'h03) |=>
        $stable(config_out.digital_output_disable))
        else $error("output disable moved");
    a_up_on_only: assert property ((clamp_out.fine_up & ~clamp_out.fine_on) == 3'h0
        && (clamp_out.coarse_up & ~clamp_out.coarse_on) == 3'h0)
        else $error("direction without clamp");
    a_fine_start: assert property (wr_ok && sub == 8'h08 && request.write_data[1]
        && !fine[1] && !timing[6] && timing[2:0] != 3'h0 |-> ##[1:3] clamp_out.fine_on[0])
        else $error("ungated clamp did not start");
    a_fine_length: assert property ($fell(clamp_out.fine_on[0]) |->
        run == {1'b0, timing[2:0]})
        else $error("fine clamp length wrong");
endmodule

/* File: vcr_host_model.sv */
// Host side of the bank's strobe port: one byte per request.
// Assumes the bench calls its tasks; drives on falling clk edges.
module vcr_host_model
(
    output vcr_pkg::vcr_reg_request_type request,
    input wire logic                     clk,
    input wire logic                     request_ack,
    input wire vcr_pkg::vcr_byte_type    read_data
);
    initial request = '0;
    // Released lines show inverted values, so stale data never looks live
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ack);
        @(negedge clk);
        request.subaddress = a;
        request.write_data = d;
        request.write = 1'b1;
        @(posedge clk);
        ack = request_ack;
        @(negedge clk);
        request.write = 1'b0;
        request.subaddress = ~a;
        request.write_data = ~d;
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        request.subaddress = a;
        request.read = 1'b1;
        @(posedge clk);
        @(negedge clk);
        request.read = 1'b0;
        request.subaddress = ~a;
        @(posedge clk);
        @(negedge clk);
        d = read_data;
    endtask
endmodule

/* File: tb_vcr_control_regs.sv */
// Self-checking bench of the codec control register bank.
// Assumes the package, the bank, the host model and the checker are compiled first.
module tb_vcr_control_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk;
    logic reset_n;
    logic sync_in;
    logic request_ack;
    int   bad_count = 0;
    int   n_compared = 0;
    vcr_pkg::vcr_reg_request_type request;
    vcr_pkg::vcr_byte_type        read_data;
    vcr_pkg::vcr_config_type      config_out;
    vcr_pkg::vcr_clamp_type       clamp_out;
    vcr_control_regs dut (.clk(clk), .reset_n(reset_n), .request(request), .request_ack(request_ack),
        .read_data(read_data), .sync_in(sync_in), .config_out(config_out), .clamp_out(clamp_out));
    vcr_host_model host (.request(request), .clk(clk), .request_ack(request_ack), .read_data(read_data));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1)
        begin
            $display("Error at %0t: %s", $time, msg);
            bad_count++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ack;
        host.write_reg(a, d, ack);
        check(ack === 1'b1, "write refused");
    endtask
    task automatic rd_check(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        host.read_reg(a, v);
        check(v === e, "read back differs");
    endtask
    // Counts on-cycles of fine (0) or coarse (1) clamp 0; up is direction at start
    task automatic measure(input int sel, output int n, output logic up);
        int i;
        n = 0;
        up = 1'b0;
        for (i = 0; i < 12 && (sel == 0 ? clamp_out.fine_on[0] : clamp_out.coarse_on[0]) !== 1'b1; i++)
            @(negedge clk);
        up = sel == 0 ? clamp_out.fine_up[0] : clamp_out.coarse_up[0];
        while ((sel == 0 ? clamp_out.fine_on[0] : clamp_out.coarse_on[0]) === 1'b1 && n < 20)
        begin
            n++;
            @(negedge clk);
        end
        if (n == 20)
        begin
            bad_count++;
            report_and_stop();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        int a;
        for (a = 1; a <= 9; a++)
            rd_check(a[7:0], 8'h00);
        check(config_out.gain_active === 1'b1, "gain not active");
        $display("test reset done");
    endtask
    task automatic t_config();
        wr(8'h01, 8'hf5);
        check(config_out.converter_power_down === 4'h5, "power bits");
        check(config_out.dual_edge_select === 1'b1, "dual edge");
        check(config_out.dual_clock_select === 1'b1, "dual clock");
        check(config_out.chroma_422_active === 1'b0, "4:2:2 not gated");
        check(config_out.converter_input_invert === 1'b1, "invert");
        wr(8'h01, 8'h4a);
        check(config_out.chroma_422_active === 1'b1, "4:2:2 off");
        check(config_out.subsampled_chroma_select === 1'b1, "4:2:2 select");
        wr(8'h02, 8'ha9);
        check(config_out.input_config === 4'h9, "input config");
        check(config_out.sha_power_down === 3'h2, "hold amp power");
        check(config_out.aux_power_down === 1'b1, "aux power");
        wr(8'h03, 8'h3b);
        check(config_out.clamp_current_half === 1'b1, "clamp current");
        check(config_out.differential_inputs === 1'b1, "input mode");
        check(config_out.sha_gain_two === 1'b0, "hold amp gain");
        check(config_out.voltage_clamp_enable === 1'b1, "voltage clamp");
        check(config_out.digital_output_disable === 1'b1, "output disable");
        check(config_out.sync_polarity_select === 1'b1, "sync polarity");
        rd_check(8'h01, 8'h4a);
        rd_check(8'h02, 8'ha9);
        $display("test config done");
    endtask
    task automatic t_gain();
        int i;
        wr(8'h04, 8'h5a);
        wr(8'h05, 8'h03);
        check(config_out.gain_multiplier === 12'h35a, "gain word");
        wr(8'h05, 8'h13);
        check(config_out.gain_active === 1'b0, "gain not gated");
        @(negedge clk);
        sync_in = 1'b1;
        @(negedge clk);
        sync_in = 1'b0;
        for (i = 0; i < 10 && config_out.gain_active !== 1'b1; i++)
            @(negedge clk);
        check(config_out.gain_active === 1'b1, "gain stayed gated");
        if (config_out.gain_active !== 1'b1)
            report_and_stop();
        wr(8'h06, 8'h55);
        check(config_out.black_level === 7'h55, "black level");
        $display("test gain done");
    endtask
    task automatic t_fine();
        int n;
        logic up;
        wr(8'h07, 8'h13);
        wr(8'h08, 8'h03);
        measure(0, n, up);
        check(n == 3 && up === 1'b1, "fine clamp run");
        wr(8'h08, 8'h03);
        measure(0, n, up);
        check(n == 0, "held trigger fired");
        wr(8'h08, 8'h00);
        wr(8'h08, 8'h02);
        measure(0, n, up);
        check(n == 3 && up === 1'b0, "fine retrigger");
        wr(8'h07, 8'h10);
        wr(8'h08, 8'h00);
        wr(8'h08, 8'h02);
        measure(0, n, up);
        check(n == 0, "zero on-time fired");
        $display("test fine done");
    endtask
    task automatic t_sync();
        int n;
        logic up;
        wr(8'h07, 8'h53);
        wr(8'h09, 8'h03);
        measure(1, n, up);
        check(n == 0, "gated clamp ran early");
        @(negedge clk);
        sync_in = 1'b1;
        @(negedge clk);
        sync_in = 1'b0;
        measure(1, n, up);
        check(n == 2 && up === 1'b1, "coarse clamp run");
        $display("test sync done");
    endtask
    task automatic t_unmapped();
        logic       ack;
        logic [7:0] v;
        rd_check(8'h03, 8'h3b);
        host.write_reg(8'h0a, 8'hff, ack);
        check(ack === 1'b0, "unmapped acked");
        host.write_reg(8'h00, 8'hff, ack);
        check(ack === 1'b0, "zero acked");
        host.read_reg(8'h0a, v);
        check(v === 8'h3b, "refused read moved");
        $display("test unmapped done");
    endtask
    task automatic t_reset_again();
        reset_n = 1'b0;
        @(negedge clk);
        check(read_data === 8'h00, "reset missed");
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
        wr(8'h05, 8'h10);
        sync_in = 1'b1;
        repeat (4) @(negedge clk);
        check(config_out.gain_active === 1'b0, "gain opened early");
        sync_in = 1'b0;
        repeat (10) if (config_out.gain_active !== 1'b1) @(negedge clk);
        check(config_out.gain_active === 1'b1, "low sync ignored");
        $display("test reset again done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial
    begin
        #100us;
        bad_count++;
        report_and_stop();
    end
    initial
    begin
        sync_in = 1'b0;
        reset_n = 1'b0;
        repeat (20) @(posedge clk);
        @(negedge clk);
        reset_n = 1'b1;
        t_reset();
        t_config();
        t_gain();
        t_fine();
        t_sync();
        t_unmapped();
        t_reset_again();
        report_and_stop();
    end
endmodule
bind vcr_control_regs vcr_control_regs_assertions u_chk (.clk(clk), .reset_n(reset_n),
    .request(request), .request_ack(request_ack), .read_data(read_data), .sync_in(sync_in),
    .config_out(config_out), .clamp_out(clamp_out));
